// File: src/dtc_pkg.sv
// Constants for the dual 8-bit timer control block.
// Assumes an AHB-Lite slave with word-aligned registers.
package dtc_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CTL0   = 8'h20;
  localparam logic [7:0] IDX_CTL1   = 8'h21;
  localparam logic [7:0] IDX_PER0   = 8'h22;
  localparam logic [7:0] IDX_PER1   = 8'h23;
  localparam logic [7:0] IDX_PW0    = 8'h24;
  localparam logic [7:0] IDX_PW1    = 8'h25;
  localparam logic [7:0] IDX_PWRCTL = 8'h26;
  localparam logic [7:0] IDX_COUNT0 = 8'h27;
  localparam logic [7:0] IDX_COUNT1 = 8'h28;
  localparam int         ADDR_LSB   = 2;
  localparam int         ADDR_MSB   = 9;

  // Reset values
  localparam logic [7:0] RST_CTL    = 8'h00;
  localparam logic [7:0] RST_TREG   = 8'hFF;
  localparam logic [7:0] RST_PWRCTL = 8'h00;

  // Control register fields
  localparam int PRESET_BIT = 7;
  localparam int CLK_MSB    = 6;
  localparam int CLK_LSB    = 4;
  localparam int RUN_BIT    = 3;
  localparam int MODE_MSB   = 2;
  localparam int MODE_LSB   = 0;

  // Power control fields
  localparam int PWR_MSB    = 1;
  localparam int PWR_LSB    = 0;
  localparam int DVSEL_BIT  = 2;

  // Prescaler width covers the deepest division
  localparam int PRE_W = 11;
  localparam int LOW_W = 3;

  typedef enum logic [2:0] {
    CLK_DIV2_11 = 3'b000,
    CLK_DIV2_7  = 3'b001,
    CLK_DIV2_5  = 3'b010,
    CLK_DIV2_3  = 3'b011,
    CLK_LOW     = 3'b100,
    CLK_DIV2    = 3'b101,
    CLK_HIGH    = 3'b110,
    CLK_EXT     = 3'b111
  } dtc_clk_t;

  typedef enum logic [2:0] {
    MODE_TIMER8   = 3'b000,
    MODE_DIVOUT8  = 3'b001,
    MODE_PWM8     = 3'b010,
    MODE_CASCADE  = 3'b011,
    MODE_TIMER16  = 3'b100,
    MODE_WARMUP   = 3'b101,
    MODE_PWM16    = 3'b110
  } dtc_mode_t;

  typedef enum logic [1:0] {
    PWR_NORMAL = 2'b00,
    PWR_SLOW   = 2'b01,
    PWR_SLEEP  = 2'b10
  } dtc_pwr_t;
endpackage : dtc_pkg

// File: src/dtc_timer_ctrl.sv
// Dual 8-bit timer control with registers on AHB-Lite.
// Two counters, each with control, period and pulse-width registers,
// plus a power control register and two read-only count snapshots.
// Pulse-width registers are storage only; waveforms are built elsewhere.
// Registers are bytes in the low lane of aligned words.
// Assumes one core clock; pin and low-clock tick inputs synchronous.
// Assumes a single slave, so hreadyout is fed back as hready.
// Power mode comes from a register here, not from the system controller.
`timescale 1ns/1ps

// Functional notes
// (RL1) Each counter has a control register, a period register and a pulse-width register.
// (RL2) The clock select field picks the prescaled, low, undivided or external count source.
// (RL3) In sleep only clock codes 000, 100 and 110 give count ticks.
// (RL4) Software keeps the low clock unselected while the low oscillator is off.
// (RL5) The first counter's mode field selects 8-bit timer, divider, PWM or cascade.
// (RL6) Clearing run stops and clears the counter; setting run starts it.
// (RL7) Software leaves mode, clock and preset alone while running or stopping.
// (RL8) Fields written together with the start take effect from that start.
// (RL9) Software fixes the first mode at 011 and picks the 16-bit mode in the second.
// (RL10) In 16-bit use, clock comes from the first control, run and preset from the second.
// (RL11) Software does not rewrite the first period register while running.
// (RL12) The first pulse-width register changes live only in PWM modes.
// (RL13) Software does not rewrite the second period register while running.
// (RL14) The second pulse-width register changes live only in PWM modes.
// (RL15) The second mode field also offers 16-bit timer, warm-up and 16-bit PWM.
// (RL16) The preset bit loads the output flip-flop cleared or set at start.
module dtc_timer_ctrl
  import dtc_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        lowClockTick,
  input  wire logic        externalCountPin,
  output logic             counter0Out,
  output logic             counter1Out
);
  import dtc_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Registers
  // Software-visible registers
  logic [7:0]       ctl0, ctl1, per0, per1, pw0, pw1, pwrCtl;
  // Counters, held clock selects and source state
  logic [7:0]       cnt0, cnt1;
  logic [2:0]       sel0, sel1;
  logic [PRE_W-1:0] pre;
  logic [LOW_W-1:0] lowDiv;
  logic             extPrev;
  logic             runPrev0, runPrev1;
  // Bus write pipeline
  logic             wrPend;
  logic [7:0]       wrIdx;

  ////////////////////////////////////////////////////////////////////////
  // Source tick select
  // One source per counter; both counters share the taps
  // (RL2) code to tick mapping
  function automatic logic srcTick(input logic [2:0] sel,
                                   input logic [PRE_W-1:0] p,
                                   input logic lowTick,
                                   input logic low8,
                                   input logic ext,
                                   input logic sleep,
                                   input logic dvSel,
                                   input logic slowMode,
                                   input logic warm);
    logic t;
    t = 1'b0;
    case (sel)
      CLK_DIV2_11: t = (sleep || dvSel) ? low8 : (&p[10:0]);
      CLK_DIV2_7:  t = &p[6:0];
      CLK_DIV2_5:  t = &p[4:0];
      CLK_DIV2_3:  t = &p[2:0];
      CLK_LOW:     t = lowTick;
      CLK_DIV2:    t = p[0];
      CLK_HIGH:    t = 1'b1;
      CLK_EXT:     t = ext;
      default:     t = 1'b0;
    endcase
    // (RL3) sleep limits codes
    if (sleep && !(sel == CLK_DIV2_11 || sel == CLK_LOW || sel == CLK_HIGH)) begin
      t = 1'b0;
    end
    // (RL3) fast clock off-normal
    // Slow or sleep lets the undivided clock drive only the warm-up count
    if ((sleep || slowMode) && sel == CLK_HIGH && !warm) begin
      t = 1'b0;
    end
    return t;
  endfunction : srcTick

  ////////////////////////////////////////////////////////////////////////
  // Bus decode
  // NONSEQ or SEQ with hready high opens an address phase
  wire       addrPhase = hsel & hready & htrans[1];
  // Index from bits 9:2; upper address bits alias
  wire [7:0] aIdx      = haddr[ADDR_MSB:ADDR_LSB];
  // Only the low byte lane carries register data
  wire [7:0] wData     = hwdata[7:0];
  wire       doWrite   = wrPend;

  ////////////////////////////////////////////////////////////////////////
  // Per-register write strobes
  wire       wrCtl0    = doWrite && (wrIdx == IDX_CTL0);
  wire       wrCtl1    = doWrite && (wrIdx == IDX_CTL1);
  wire       wrPer0    = doWrite && (wrIdx == IDX_PER0);
  wire       wrPer1    = doWrite && (wrIdx == IDX_PER1);
  wire       wrPw0     = doWrite && (wrIdx == IDX_PW0);
  wire       wrPw1     = doWrite && (wrIdx == IDX_PW1);
  wire       wrPwrCtl  = doWrite && (wrIdx == IDX_PWRCTL);
  wire [7:0] rdByte    = (aIdx == IDX_CTL0)   ? ctl0 :
                         (aIdx == IDX_CTL1)   ? ctl1 :
                         (aIdx == IDX_PER0)   ? per0 :
                         (aIdx == IDX_PER1)   ? per1 :
                         (aIdx == IDX_PW0)    ? pw0 :
                         (aIdx == IDX_PW1)    ? pw1 :
                         (aIdx == IDX_PWRCTL) ? pwrCtl :
                         (aIdx == IDX_COUNT0) ? cnt0 :
                         (aIdx == IDX_COUNT1) ? cnt1 : 8'h00;

  ////////////////////////////////////////////////////////////////////////
  // Control decode
  wire [2:0] mode0   = ctl0[MODE_MSB:MODE_LSB];
  wire [2:0] mode1   = ctl1[MODE_MSB:MODE_LSB];
  // (RL5) cascade selected by 011
  // (RL15) second mode 1xx is 16-bit
  wire       is16    = (mode0 == MODE_CASCADE) && mode1[2];
  // (RL10) run and preset from second
  wire       run1    = ctl1[RUN_BIT];
  wire       run0    = is16 ? run1 : ctl0[RUN_BIT];
  wire       pre0    = is16 ? ctl1[PRESET_BIT] : ctl0[PRESET_BIT];

  // Power mode and divider source
  wire       sleep   = pwrCtl[PWR_MSB];
  wire       dvSel   = pwrCtl[DVSEL_BIT];
  wire       slowMode = (pwrCtl[PWR_MSB:PWR_LSB] == PWR_SLOW);
  // Warm-up runs as a cascaded pair in the second mode field
  wire       warm    = is16 && (mode1 == MODE_WARMUP);

  // Count sources; low clock over eight for the 2^11 tap in sleep or with dvSel
  wire       low8    = lowClockTick & (&lowDiv);
  wire       extTick = externalCountPin & ~extPrev;
  // (RL10) clock from first control
  // (RL8) select held from the start
  wire       tick0   = srcTick(sel0, pre, lowClockTick, low8,
                               extTick, sleep, dvSel, slowMode, warm);
  wire       tick1n  = srcTick(sel1, pre, lowClockTick, low8,
                               extTick, sleep, dvSel, slowMode, warm);

  // Compare and carry
  // Low byte carries at all ones only when the 16-bit compare misses
  wire       match16 = ({cnt1, cnt0} == {per1, per0});
  wire       match0  = is16 ? match16 : (cnt0 == per0);
  wire       match1  = (cnt1 == per1);
  wire       carry0  = is16 & tick0 & (cnt0 == 8'hFF) & ~match16;
  wire       tick1   = is16 ? carry0 : tick1n;

  // Run rising edges
  wire       start0  = run0 & ~runPrev0;
  wire       start1  = run1 & ~runPrev1;

  ////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave, zero wait states
  // Writes land an edge later, when their data phase stands on hwdata
  // Reads sample in the address phase; hresp stays OKAY
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
      wrPend    <= 1'b0;
      wrIdx     <= 8'h00;
    end else begin
      wrPend <= addrPhase & hwrite;
      wrIdx  <= aIdx;
      if (addrPhase && !hwrite) begin
        hrdata <= {24'h00_0000, rdByte};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register writes
  // (RL1) control, period, pulse width
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl0   <= RST_CTL;
      ctl1   <= RST_CTL;
      per0   <= RST_TREG;
      per1   <= RST_TREG;
      pw0    <= RST_TREG;
      pw1    <= RST_TREG;
      pwrCtl <= RST_PWRCTL;
    end else begin
      // Count snapshots and unmapped places drop writes
      if (wrCtl0) ctl0 <= wData;
      if (wrCtl1) ctl1 <= wData;
      if (wrPer0) per0 <= wData;
      if (wrPer1) per1 <= wData;
      if (wrPw0) pw0 <= wData;
      if (wrPw1) pw1 <= wData;
      if (wrPwrCtl) pwrCtl <= wData;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Prescaler and source edge tracking
  // Divided taps are all-ones decodes of the free-running count, except 2^11, which takes low8 in sleep or with dvSel
  // The pin tracker resets low, so a pin high out of reset counts once
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre     <= '0;
      lowDiv  <= '0;
      extPrev <= 1'b0;
    end else begin
      pre     <= pre + 1'b1;
      extPrev <= externalCountPin;
      if (lowClockTick) begin
        lowDiv <= lowDiv + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // First counter and its output flip-flop
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt0        <= 8'h00;
      runPrev0    <= 1'b0;
      counter0Out <= 1'b0;
      sel0        <= 3'h0;
    end else begin
      // Start wins over a tick in the same cycle
      runPrev0 <= run0;
      // (RL6) stop clears counter
      if (!run0) begin
        cnt0 <= 8'h00;
      // (RL8) fields applied at start
      // (RL16) preset loads flip-flop
      end else if (start0) begin
        cnt0        <= 8'h00;
        counter0Out <= pre0;
        sel0        <= ctl0[CLK_MSB:CLK_LSB];
      // Match wraps to zero, so a period of N spans N+1 ticks
      end else if (tick0) begin
        if (match0) begin
          cnt0        <= 8'h00;
          counter0Out <= ~counter0Out;
        end else begin
          cnt0 <= cnt0 + 8'h01;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Second counter; upper byte when cascaded
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt1        <= 8'h00;
      runPrev1    <= 1'b0;
      counter1Out <= 1'b0;
      sel1        <= 3'h0;
    end else begin
      // Cascaded: the low byte carry is the only tick
      runPrev1 <= run1;
      // (RL6) stop clears counter
      if (!run1) begin
        cnt1 <= 8'h00;
      // (RL16) preset loads flip-flop
      end else if (start1) begin
        cnt1        <= 8'h00;
        counter1Out <= ctl1[PRESET_BIT];
        sel1        <= ctl1[CLK_MSB:CLK_LSB];
      // (RL10) 16-bit match ends the period
      end else if (is16 && tick0 && match16) begin
        cnt1        <= 8'h00;
        counter1Out <= ~counter1Out;
      end else if (tick1) begin
        if (!is16 && match1) begin
          cnt1        <= 8'h00;
          counter1Out <= ~counter1Out;
        end else begin
          cnt1 <= cnt1 + 8'h01;
        end
      end
    end
  end

endmodule : dtc_timer_ctrl

// File: sim/dtc_props.sv
// Port checker for the dual timer control block.
// Bound to dtc_timer_ctrl; shadows landed control and power writes.
`timescale 1ns/1ps
module dtc_props
  import dtc_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        lowClockTick,
  input wire logic        externalCountPin,
  input wire logic        counter0Out,
  input wire logic        counter1Out
);
  logic [7:0] c0, c1, pw, ix;
  logic       wp;
  logic [1:0] q;
  // Request decode and sleep-dead codes
  wire        rq = hsel & hready & htrans[1];
  wire        noTick = !(c0[6:4] inside {3'h0, 3'h4, 3'h6});
  // Shadow registers and quiet counter
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      {c0, c1, pw, ix, wp, q} <= '0;
    end else begin
      wp <= rq & hwrite;
      ix <= haddr[9:2];
      if (wp) q <= 2'h0;
      else if (q != 2'h3) q <= q + 2'h1;
      if (wp && ix == IDX_CTL0) c0 <= hwdata[7:0];
      if (wp && ix == IDX_CTL1) c1 <= hwdata[7:0];
      if (wp && ix == IDX_PWRCTL) pw <= hwdata[7:0];
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_go0; wp && ix == IDX_CTL0 && hwdata[3] && !c0[3] && hwdata[2:0] != 3'h3; endsequence
  sequence s_go1; wp && ix == IDX_CTL1 && hwdata[3] && !c1[3]; endsequence
  property p_rdy; hreadyout && !hresp && hrdata[31:8] == 24'h0; endproperty
  property p_unm; rq && !hwrite && haddr[9:2] > IDX_COUNT1 |=> hrdata == 32'h0; endproperty
  property p_go0; s_go0 |-> ##2 counter0Out == $past(hwdata[7], 2); endproperty
  property p_go1; s_go1 |-> ##2 counter1Out == $past(hwdata[7], 2); endproperty
  property p_casc;
    s_go1 ##0 (c0[2:0] == 3'h3 && hwdata[2]) |-> ##2 counter0Out == $past(hwdata[7], 2);
  endproperty
  property p_stop0; !c0[3] && !c1[3] && q == 2'h3 |-> $stable(counter0Out); endproperty
  property p_stop1; !c1[3] && q == 2'h3 |-> $stable(counter1Out); endproperty
  property p_sleep0; pw[1] && noTick && c0[2:0] != 3'h3 && q == 2'h3 |-> $stable(counter0Out);
  endproperty
  a_rdy: assert property (p_rdy) else $error("bus answer not okay");
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  a_go0: assert property (p_go0) else $error("first start preset wrong");
  a_go1: assert property (p_go1) else $error("second start preset wrong");
  a_casc: assert property (p_casc) else $error("cascade preset wrong");
  a_stop0: assert property (p_stop0) else $error("first output moved stopped");
  a_stop1: assert property (p_stop1) else $error("second output moved stopped");
  a_sleep0: assert property (p_sleep0) else $error("dead code ticked in sleep");
endmodule : dtc_props
bind dtc_timer_ctrl dtc_props dtc_props_inst (.core_clk(core_clk), .rst_n(rst_n),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
  .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .lowClockTick(lowClockTick), .externalCountPin(externalCountPin),
  .counter0Out(counter0Out), .counter1Out(counter1Out));

// File: sim/dtc_timer_ctrl_test.sv
// Testbench for the dual timer control block.
// Drives AHB-Lite and both count sources; one slave.
`timescale 1ns/1ps
module dtc_timer_ctrl_test;
  import dtc_pkg::*;
  logic        core_clk = 1'b0, rst_n = 1'b0, hwrite = 1'b0, lowTick = 1'b0, pin = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
  logic        hreadyout, hresp, o0, o1;
  int          errCount = 0, checkCount = 0, cyc = 0, n;
  int          tb[14][3] = '{'{6, 0, 1}, '{5, 0, 2}, '{3, 0, 8}, '{2, 0, 32}, '{1, 0, 128},
    '{0, 0, 2048}, '{0, 4, 40}, '{4, 1, 5}, '{7, 0, 6}, '{0, 2, 40}, '{6, 2, 4200},
    '{4, 2, 5}, '{1, 2, 4200}, '{7, 2, 4200}};
  dtc_timer_ctrl dtc_timer_ctrl_inst (.core_clk(core_clk), .rst_n(rst_n), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .lowClockTick(lowTick), .externalCountPin(pin), .counter0Out(o0), .counter1Out(o1));
  always #20 core_clk = ~core_clk;
  // Low tick every 5 cycles, pin rise every 6
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    lowTick <= (cyc % 5 == 0);
    pin <= (cyc % 6 < 3);
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checkCount++;
    if (s !== e) begin
      errCount++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  // One single transfer, read data into r
  task automatic xfer(input logic [7:0] i, input logic w, input logic [31:0] d);
    haddr <= {22'h0, i, 2'h0};
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    r = hrdata;
  endtask : xfer
  // Cycles until the chosen output flips
  task automatic tog(input logic s);
    logic v;
    v = s ? o1 : o0;
    n = 0;
    while ((s ? o1 : o0) === v && n < 4200) begin
      @(negedge core_clk);
      n++;
    end
  endtask : tog
  // Start, time a full flip interval, stop with fields kept
  task automatic meas(input logic [7:0] i, input logic [7:0] v, input logic s, input int e);
    xfer(i, 1'b1, {24'h0, v});
    repeat (3) tog(s);
    chk(n, e);
    xfer(i, 1'b1, {24'h0, v & 8'hF7});
  endtask : meas
  task automatic printVerdict();
    $display("checks %0d errors %0d", checkCount, errCount);
    if (errCount == 0 && checkCount > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : printVerdict
  initial begin
    #3200000;
    errCount++;
    printVerdict();
  end
  initial begin
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    // Reset values, readback, unmapped place
    for (int i = 8'h20; i < 8'h27; i++) begin
      xfer(i[7:0], 1'b0, 32'h0);
      chk(r, (i < 8'h22 || i == 8'h26) ? 32'h0 : 32'hFF);
      xfer(i[7:0], 1'b1, 32'hFFFFFF52 ^ i);
      xfer(i[7:0], 1'b0, 32'h0);
      chk(r, 32'h52 ^ i);
    end
    xfer(8'h30, 1'b1, 32'h5A);
    xfer(8'h30, 1'b0, 32'h0);
    chk(r, 32'h0);
    $display("test registers done");
    // Every count source and power mode
    xfer(IDX_CTL1, 1'b1, 32'h0);
    xfer(IDX_CTL0, 1'b1, 32'h0);
    xfer(IDX_PER0, 1'b1, 32'h0);
    for (int k = 0; k < 14; k++) begin
      xfer(IDX_PWRCTL, 1'b1, tb[k][1]);
      meas(IDX_CTL0, {k[0], tb[k][0][2:0], 1'b1, 3'(k % 3)}, 1'b0, tb[k][2]);
    end
    $display("test sources done");
    // Cascaded modes: clock from first, run from second
    xfer(IDX_PWRCTL, 1'b1, 32'h0);
    xfer(IDX_PER1, 1'b1, 32'h1);
    xfer(IDX_CTL0, 1'b1, 32'h63);
    for (int m = 4; m < 7; m++) meas(IDX_CTL1, {m[0], 4'h3, m[2:0]}, 1'b1, 257);
    // Live pulse-width updates in 16-bit PWM
    xfer(IDX_CTL1, 1'b1, 32'h3E);
    xfer(IDX_PW0, 1'b1, 32'h3C);
    xfer(IDX_PW1, 1'b1, 32'hC3);
    xfer(IDX_PW0, 1'b0, 32'h0);
    chk(r, 32'h3C);
    xfer(IDX_PW1, 1'b0, 32'h0);
    chk(r, 32'hC3);
    xfer(IDX_CTL1, 1'b1, 32'h36);
    // Warm-up in sleep keeps the undivided clock
    xfer(IDX_PWRCTL, 1'b1, 32'h2);
    meas(IDX_CTL1, 8'h3D, 1'b1, 257);
    $display("test cascade done");
    printVerdict();
  end
endmodule : dtc_timer_ctrl_test
